// ### src_reset_consts.vh
// Constants for the system reset combiner: widths, offsets, bit layout, reset values
`ifndef SRC_RESET_CONSTS_VH
`define SRC_RESET_CONSTS_VH

`define SRC_DATA_W 16
`define SRC_ADDR_W 4
`define SRC_NUM_SRC 11
`define SRC_NUM_SYNC 3
`define SRC_OSC_W 3
`define SRC_PC_W 24

`define SRC_OFF_CAUSE 4'h0
`define SRC_OFF_OSC 4'h1
`define SRC_OFF_IRQ_STS 4'h2
`define SRC_OFF_IRQ_EN 4'h3
`define SRC_OFF_IRQ_CLR 4'h4
`define SRC_OFF_LIVE 4'h5

`define SRC_BIT_POR 0
`define SRC_BIT_BOR 1
`define SRC_BIT_SWR 2
`define SRC_BIT_WDT 3
`define SRC_BIT_CFG 4
`define SRC_BIT_TRAP 5
`define SRC_BIT_ILL 6
`define SRC_BIT_MASTER_CLEAR_PIN 7
`define SRC_BIT_OPC 8
`define SRC_BIT_UWR 9
`define SRC_BIT_SEC 10

`define SRC_SYNC_POR 0
`define SRC_SYNC_BOR 1
`define SRC_SYNC_MASTER_CLEAR_PIN 2

`define SRC_OSC_LSB 8
`define SRC_OSC_MSB 10

`define SRC_CAUSE_POR_VAL 11'h003
`define SRC_ZERO_CAUSE 11'h000
`define SRC_RESET_PC 24'h000000
`define SRC_ZERO_DATA 16'h0000
`define SRC_ZERO_OSC 3'h0
`define SRC_SYNC_IDLE 3'h0

`endif

// ### src_reset_combiner.v
// System reset combiner: merges reset sources, records causes, seeds oscillator select
//
// Notes on behaviour
// - Merge all eleven reset sources into one
// - Any active source asserts master reset, unmasked
// - Reset forces chosen registers, leaves others alone
// - Each reset type sets its own cause flag
// - Power-on clears flags, sets bits one, zero
// - Software writes any cause flag, value kept
// - Flags are status only, never cause reset
// - Every reset copies oscillator choice into bits 10:8
// - Reset never raised as an interrupt exception
// - Reset clears registers, program counter to zero
//
// Implementation choices: strobed register access and the register addresses.
`include "src_reset_consts.vh"

module src_reset_combiner (
   input wire CLK,
   input wire SYS_RST,
   input wire POWER_ON_RESET,
   input wire BROWN_OUT_RESET,
   input wire MASTER_CLEAR_PIN_N,
   input wire SOFTWARE_RESET_INSTR,
   input wire WATCHDOG_TIMEOUT,
   input wire CONFIG_MISMATCH,
   input wire TRAP_CONFLICT,
   input wire ILLEGAL_CONDITION,
   input wire ILLEGAL_OPCODE,
   input wire UNINIT_WREG,
   input wire SECURITY_RESET,
   input wire [`SRC_OSC_W-1:0] INITIAL_OSC_CHOICE,
   input wire [`SRC_ADDR_W-1:0] ADDR,
   input wire [`SRC_DATA_W-1:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [`SRC_DATA_W-1:0] RDATA,
   output reg MASTER_SYSTEM_RESET,
   output reg [`SRC_OSC_W-1:0] NEW_OSC_SELECT,
   output reg PC_LOAD,
   output reg [`SRC_PC_W-1:0] RESET_PC,
   output reg IRQ
);

   // Pin-level sources come from analog or pad logic outside CLK
   wire [`SRC_NUM_SYNC-1:0] async_in;
   reg [`SRC_NUM_SYNC-1:0] sync1_reg;
   reg [`SRC_NUM_SYNC-1:0] sync2_reg;
   wire [`SRC_NUM_SYNC-1:0] sync1_next;
   wire [`SRC_NUM_SYNC-1:0] sync2_next;
   wire por_sync;
   wire bor_sync;
   wire master_clear_pin_sync;

   wire [`SRC_NUM_SRC-1:0] src_vec;
   reg [`SRC_NUM_SRC-1:0] src_prev_reg;
   wire [`SRC_NUM_SRC-1:0] src_rise;
   wire any_src;

   reg [`SRC_NUM_SRC-1:0] cause_reg;
   wire [`SRC_NUM_SRC-1:0] cause_next;
   reg [`SRC_NUM_SRC-1:0] sts_reg;
   wire [`SRC_NUM_SRC-1:0] sts_next;
   reg [`SRC_NUM_SRC-1:0] en_reg;
   reg [`SRC_NUM_SRC-1:0] en_next;

   reg [`SRC_OSC_W-1:0] osc_reg;
   reg [`SRC_OSC_W-1:0] osc_next;

   reg mrst_next;
   reg irq_next;
   reg pc_load_next;
   reg [`SRC_DATA_W-1:0] rdata_next;

   wire wr_cause;
   wire wr_osc;
   wire wr_en;
   wire wr_clr;
   wire por_active;
   wire [`SRC_NUM_SRC-1:0] irq_src;
   localparam [`SRC_NUM_SRC-1:0] por_cause = `SRC_CAUSE_POR_VAL;

   // Master clear is active low at the pin; inverted so every stage is active high
   assign async_in[`SRC_SYNC_POR] = POWER_ON_RESET;
   assign async_in[`SRC_SYNC_BOR] = BROWN_OUT_RESET;
   assign async_in[`SRC_SYNC_MASTER_CLEAR_PIN] = ~MASTER_CLEAR_PIN_N;
   assign sync1_next = async_in;
   assign sync2_next = sync1_reg;

   // Synchroniser stage one only feeds stage two; idle value is inactive
   always @(posedge CLK) begin
      if (SYS_RST) begin
         sync1_reg <= `SRC_SYNC_IDLE;
      end else begin
         sync1_reg <= sync1_next;
      end
   end

   // Stage two is the only reader of stage one, so a metastable level settles first
   always @(posedge CLK) begin
      if (SYS_RST) begin
         sync2_reg <= `SRC_SYNC_IDLE;
      end else begin
         sync2_reg <= sync2_next;
      end
   end

   // Synchronised pin levels
   assign por_sync = sync2_reg[`SRC_SYNC_POR];
   assign bor_sync = sync2_reg[`SRC_SYNC_BOR];
   assign master_clear_pin_sync = sync2_reg[`SRC_SYNC_MASTER_CLEAR_PIN];

   // Source vector laid out exactly as the cause flags
   assign src_vec[`SRC_BIT_POR] = por_sync;
   assign src_vec[`SRC_BIT_BOR] = bor_sync;
   assign src_vec[`SRC_BIT_MASTER_CLEAR_PIN] = master_clear_pin_sync;
   assign src_vec[`SRC_BIT_SWR] = SOFTWARE_RESET_INSTR;
   assign src_vec[`SRC_BIT_WDT] = WATCHDOG_TIMEOUT;
   assign src_vec[`SRC_BIT_CFG] = CONFIG_MISMATCH;
   assign src_vec[`SRC_BIT_TRAP] = TRAP_CONFLICT;
   assign src_vec[`SRC_BIT_ILL] = ILLEGAL_CONDITION;
   assign src_vec[`SRC_BIT_OPC] = ILLEGAL_OPCODE;
   assign src_vec[`SRC_BIT_UWR] = UNINIT_WREG;
   assign src_vec[`SRC_BIT_SEC] = SECURITY_RESET;

   // Plain OR: no priority, no mask, flags play no part
   assign any_src = |src_vec;
   assign por_active = src_vec[`SRC_BIT_POR];
   assign src_rise = src_vec & ~src_prev_reg;

   assign wr_cause = WR && (ADDR == `SRC_OFF_CAUSE);
   assign wr_osc = WR && (ADDR == `SRC_OFF_OSC);
   assign wr_en = WR && (ADDR == `SRC_OFF_IRQ_EN);
   assign wr_clr = WR && (ADDR == `SRC_OFF_IRQ_CLR);

   // Per-flag next values for cause flags and interrupt status
   genvar i;
   generate
      for (i = 0; i < `SRC_NUM_SRC; i = i + 1) begin : g_flag
         reg cause_bit_next;
         reg sts_bit_next;
         // Power-on overrides; an active source beats a software write
         always @* begin
            if (por_active) begin
               cause_bit_next = por_cause[i];
            end else if (src_vec[i]) begin
               cause_bit_next = 1'h1;
            end else if (wr_cause) begin
               cause_bit_next = WDATA[i];
            end else begin
               cause_bit_next = cause_reg[i];
            end
         end
         assign cause_next[i] = cause_bit_next;
         // Event set wins over a clear arriving in the same cycle
         always @* begin
            if (src_rise[i]) begin
               sts_bit_next = 1'h1;
            end else if (wr_clr && WDATA[i]) begin
               sts_bit_next = 1'h0;
            end else begin
               sts_bit_next = sts_reg[i];
            end
         end
         assign sts_next[i] = sts_bit_next;
      end
   endgenerate

   // Master reset is a registered OR, so release lands on a clock edge
   always @* begin
      if (any_src) begin
         mrst_next = 1'h1;
      end else begin
         mrst_next = 1'h0;
      end
   end

   // Restart pulse marks the single cycle after master reset lets go
   always @* begin
      if (MASTER_SYSTEM_RESET && !any_src) begin
         pc_load_next = 1'h1;
      end else begin
         pc_load_next = 1'h0;
      end
   end

   // Oscillator select is reloaded during every reset, else software owns it
   always @* begin
      if (any_src) begin
         osc_next = INITIAL_OSC_CHOICE;
      end else if (wr_osc) begin
         osc_next = WDATA[`SRC_OSC_MSB:`SRC_OSC_LSB];
      end else begin
         osc_next = osc_reg;
      end
   end

   // Enable register belongs to the subset that master reset clears;
   // cause flags and status survive so software can see what happened
   always @* begin
      if (any_src) begin
         en_next = `SRC_ZERO_CAUSE;
      end else if (wr_en) begin
         en_next = WDATA[`SRC_NUM_SRC-1:0];
      end else begin
         en_next = en_reg;
      end
   end

   // Interrupt reports past events only; the reset itself is never an exception
   assign irq_src = sts_next & en_next;
   always @* begin
      if (|irq_src) begin
         irq_next = 1'h1;
      end else begin
         irq_next = 1'h0;
      end
   end

   // Read mux: data stand the cycle after the strobe; unmapped reads zero
   always @* begin
      rdata_next = `SRC_ZERO_DATA;
      if (RD) begin
         case (ADDR)
            `SRC_OFF_CAUSE: begin
               rdata_next[`SRC_NUM_SRC-1:0] = cause_reg;
            end
            `SRC_OFF_OSC: begin
               rdata_next[`SRC_OSC_MSB:`SRC_OSC_LSB] = osc_reg;
            end
            `SRC_OFF_IRQ_STS: begin
               rdata_next[`SRC_NUM_SRC-1:0] = sts_reg;
            end
            `SRC_OFF_IRQ_EN: begin
               rdata_next[`SRC_NUM_SRC-1:0] = en_reg;
            end
            `SRC_OFF_IRQ_CLR: begin
               rdata_next = `SRC_ZERO_DATA;
            end
            `SRC_OFF_LIVE: begin
               rdata_next[`SRC_NUM_SRC-1:0] = src_vec;
            end
            default: begin
               rdata_next = `SRC_ZERO_DATA;
            end
         endcase
      end
   end

   // Block reset loads the power-on cause value; status, enable and oscillator select load zero
   always @(posedge CLK) begin
      if (SYS_RST) begin
         cause_reg <= `SRC_CAUSE_POR_VAL;
      end else begin
         cause_reg <= cause_next;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         sts_reg <= `SRC_ZERO_CAUSE;
      end else begin
         sts_reg <= sts_next;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         en_reg <= `SRC_ZERO_CAUSE;
      end else begin
         en_reg <= en_next;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         osc_reg <= `SRC_ZERO_OSC;
      end else begin
         osc_reg <= osc_next;
      end
   end

   // Edge memory starts at the idle level, so no false event follows block reset
   always @(posedge CLK) begin
      if (SYS_RST) begin
         src_prev_reg <= `SRC_ZERO_CAUSE;
      end else begin
         src_prev_reg <= src_vec;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         MASTER_SYSTEM_RESET <= 1'h1;
      end else begin
         MASTER_SYSTEM_RESET <= mrst_next;
      end
   end

   // Follows the next value so the clock choice shows on the register's own edge
   always @(posedge CLK) begin
      if (SYS_RST) begin
         NEW_OSC_SELECT <= `SRC_ZERO_OSC;
      end else begin
         NEW_OSC_SELECT <= osc_next;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         PC_LOAD <= 1'h0;
      end else begin
         PC_LOAD <= pc_load_next;
      end
   end

   // Constant vector kept in a flop so every output is registered
   always @(posedge CLK) begin
      if (SYS_RST) begin
         RESET_PC <= `SRC_RESET_PC;
      end else begin
         RESET_PC <= `SRC_RESET_PC;
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         IRQ <= 1'h0;
      end else begin
         IRQ <= irq_next;
      end
   end

   // Zero outside the answer cycle keeps a shared read bus quiet
   always @(posedge CLK) begin
      if (SYS_RST) begin
         RDATA <= `SRC_ZERO_DATA;
      end else begin
         RDATA <= rdata_next;
      end
   end

endmodule

// ### src_reset_checker.sv
// Port assertions for the system reset combiner
module src_reset_checker (
   input wire CLK,
   input wire SYS_RST,
   input wire SOFTWARE_RESET_INSTR,
   input wire WATCHDOG_TIMEOUT,
   input wire MASTER_CLEAR_PIN_N,
   input wire [2:0] INITIAL_OSC_CHOICE,
   input wire [3:0] ADDR,
   input wire WR,
   input wire RD,
   input wire [15:0] RDATA,
   input wire MASTER_SYSTEM_RESET,
   input wire [2:0] NEW_OSC_SELECT,
   input wire PC_LOAD,
   input wire [23:0] RESET_PC
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   src_sets_a: assert property ((WATCHDOG_TIMEOUT || SOFTWARE_RESET_INSTR)
      |=> MASTER_SYSTEM_RESET) else $error("source gave no reset");
   pin_sets_a: assert property (!MASTER_CLEAR_PIN_N [*3] |=> MASTER_SYSTEM_RESET)
      else $error("pin gave no reset");
   // Skip the drop that follows a block reset, where no restart is owed
   restart_pc_a: assert property ($fell(MASTER_SYSTEM_RESET) && !$past(SYS_RST, 2)
      |-> PC_LOAD && RESET_PC == 24'h000000) else $error("no restart at zero");
   pc_pulse_a: assert property (PC_LOAD |=> !PC_LOAD)
      else $error("restart pulse too long");
   idle_release_a: assert property ($fell(MASTER_SYSTEM_RESET)
      |-> !$past(WATCHDOG_TIMEOUT) && !$past(SOFTWARE_RESET_INSTR)) else $error("early release");
   osc_copy_a: assert property ($rose(MASTER_SYSTEM_RESET)
      |-> NEW_OSC_SELECT == INITIAL_OSC_CHOICE) else $error("osc choice not copied");
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
      else $error("stray read data");
   flag_write_a: assert property (WR && ADDR == 4'h0 && !MASTER_SYSTEM_RESET
      |=> !MASTER_SYSTEM_RESET) else $error("flag write caused reset");
endmodule
bind src_reset_combiner src_reset_checker u_src_reset_checker (.*);

// ### src_cpu_model.sv
// CPU stand-in that restarts from the reset vector
module src_cpu_model (
   input wire clk,
   input wire master_rst,
   input wire pc_load,
   input wire [23:0] reset_pc,
   output logic [23:0] pc_reg,
   output logic [15:0] boots_reg
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      boots_reg = 16'h0000;
   end
   always @(posedge clk) begin
      if (pc_load) begin
         pc_reg <= reset_pc;
         boots_reg <= boots_reg + 16'h0001;
      end else if (!master_rst) begin
         pc_reg <= pc_reg + 24'h000001;
      end
   end
endmodule

// ### tb.sv
// Directed test of the reset combiner through its register port
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK, SYS_RST, WR, RD;
   logic [10:0] src;
   logic [2:0] INITIAL_OSC_CHOICE;
   logic [3:0] ADDR;
   logic [15:0] WDATA, b0;
   wire [15:0] RDATA, boots;
   wire [2:0] NEW_OSC_SELECT;
   wire [23:0] RESET_PC, pc;
   wire MASTER_SYSTEM_RESET, PC_LOAD, IRQ;
   int miscompares = 0;
   int n_compared = 0;
   src_reset_combiner u_src_reset_combiner (.CLK, .SYS_RST, .POWER_ON_RESET(src[0]),
      .BROWN_OUT_RESET(src[1]), .MASTER_CLEAR_PIN_N(~src[7]), .SOFTWARE_RESET_INSTR(src[2]),
      .WATCHDOG_TIMEOUT(src[3]), .CONFIG_MISMATCH(src[4]), .TRAP_CONFLICT(src[5]),
      .ILLEGAL_CONDITION(src[6]), .ILLEGAL_OPCODE(src[8]), .UNINIT_WREG(src[9]),
      .SECURITY_RESET(src[10]), .INITIAL_OSC_CHOICE, .ADDR, .WDATA, .WR, .RD, .RDATA,
      .MASTER_SYSTEM_RESET, .NEW_OSC_SELECT, .PC_LOAD, .RESET_PC, .IRQ);
   src_cpu_model u_src_cpu_model (.clk(CLK), .master_rst(MASTER_SYSTEM_RESET),
      .pc_load(PC_LOAD), .reset_pc(RESET_PC), .pc_reg(pc), .boots_reg(boots));
   task chk(input [15:0] s, input [15:0] e);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %0t seen %h want %h", $time, s, e);
      end
   endtask
   task report_and_stop;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task wr(input [3:0] a, input [15:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'h1;
      @(posedge CLK);
      WR <= 1'h0;
   endtask
   task rd(input [3:0] a, input [15:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'h1;
      @(posedge CLK);
      RD <= 1'h0;
      #1 chk(RDATA, e);
   endtask
   // Bounded wait; a hang ends the run as a failure
   task wait_rst(input v);
      int k;
      k = 0;
      do begin
         @(posedge CLK);
         #1 k++;
      end while (MASTER_SYSTEM_RESET !== v && k < 20);
      if (k == 20) begin
         miscompares++;
         report_and_stop;
      end
   endtask
   initial begin
      CLK = 1'h0;
      forever #5 CLK = ~CLK;
   end
   initial begin
      SYS_RST = 1'h1;
      WR = 1'h0;
      RD = 1'h0;
      ADDR = 4'h0;
      WDATA = 16'h0000;
      src = 11'h000;
      INITIAL_OSC_CHOICE = 3'h0;
      repeat (2) @(posedge CLK);
      SYS_RST <= 1'h0;
      rd(4'h0, 16'h0003);
      rd(4'h1, 16'h0000);
      rd(4'hF, 16'h0000);
      wr(4'h0, 16'hFFFF);
      rd(4'h0, 16'h07FF);
      chk(MASTER_SYSTEM_RESET, 1'h0);
      $display("test flags done");
      for (int i = 0; i < 11; i++) begin
         wr(4'h0, 16'h0000);
         wr(4'h3, 16'h0008);
         b0 = boots;
         src[i] <= 1'h1;
         INITIAL_OSC_CHOICE <= i[2:0];
         wait_rst(1'h1);
         rd(4'h5, 16'h0001 << i);
         @(posedge CLK);
         src[i] <= 1'h0;
         wait_rst(1'h0);
         rd(4'h0, (i == 0) ? 16'h0003 : 16'h0001 << i);
         rd(4'h1, {5'h00, i[2:0], 8'h00});
         chk(NEW_OSC_SELECT, i[2:0]);
         chk(boots - b0, 16'h0001);
         chk(pc[15:0], 16'h0003);
         chk(IRQ, 1'h0);
      end
      $display("test sources done");
      wr(4'h2, 16'h0000);
      rd(4'h2, 16'h07FF);
      wr(4'h3, 16'h0008);
      repeat (2) @(posedge CLK);
      #1 chk(IRQ, 1'h1);
      wr(4'h4, 16'h07FF);
      repeat (2) @(posedge CLK);
      #1 chk(IRQ, 1'h0);
      rd(4'h2, 16'h0000);
      $display("test irq done");
      report_and_stop;
   end
endmodule
